// ==== opt_pkg.sv ====
// ****************************************************************
// Output pulse timer constants and types
// ****************************************************************
package opt_pkg;

   // ****************************************************************
   // Clock and tick timing
   // ****************************************************************
   localparam int CLK_PERIOD_PS  = 5000;     // System clock period
   localparam int TICK_PERIOD_US = 1;        // Timer tick period
   localparam int PS_PER_US      = 1000000;  // Unit conversion
   // Clock cycles per tick, rounded down, never below one
   localparam int TICK_CYC_RAW   = (TICK_PERIOD_US * PS_PER_US)
                                   / CLK_PERIOD_PS;
   localparam int TICK_CYC       = (TICK_CYC_RAW < 1) ? 1 : TICK_CYC_RAW;

   // ****************************************************************
   // Widths and limits
   // ****************************************************************
   localparam int ADDR_W    = 8;             // Register address width
   localparam int DATA_W    = 32;            // Register data width
   localparam int COUNT_W   = 12;            // Count setting width
   localparam int BASE_W    = 16;            // Tick base width
   localparam int REMAIN_W  = COUNT_W + BASE_W; // Product width
   localparam int NUM_W     = DATA_W + 1;    // Rounded dividend width

   localparam logic [COUNT_W-1:0] DLY_COUNT_MIN = 12'h000;
   localparam logic [COUNT_W-1:0] DUR_COUNT_MIN = 12'h001;
   localparam logic [COUNT_W-1:0] COUNT_MAX     = 12'hfff;
   localparam logic [BASE_W-1:0]  BASE_MIN      = 16'h0001;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [COUNT_W-1:0] DLY_COUNT_RST = 12'h000;
   localparam logic [COUNT_W-1:0] DUR_COUNT_RST = 12'h001;
   localparam logic [BASE_W-1:0]  BASE_RST      = 16'h0001;

   // ****************************************************************
   // Register offsets (byte addresses)
   // ****************************************************************
   localparam logic [ADDR_W-1:0] OFS_DLY_COUNT = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_DLY_BASE  = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_DLY_ABS   = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_DUR_COUNT = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_DUR_BASE  = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_DUR_ABS   = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_OUT_LEVEL = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_SNAPSHOT  = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h20;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int SNAP_IN_BIT   = 0;         // Input line level
   localparam int SNAP_OUT_BIT  = 16;        // Output line level
   localparam int STAT_BUSY_BIT = 0;         // Conversion running
   localparam int STAT_RUN_BIT  = 1;         // Timer not idle

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      OPT_IDLE,
      OPT_DELAY,
      OPT_HIGH
   } opt_phase_t;

   // Register port request
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } opt_req_t;

endpackage

// ==== opt_round_div.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Serial restoring divider, one quotient bit per cycle
// ****************************************************************
module opt_round_div
   import opt_pkg::*;
#(
   parameter int NW = NUM_W,                 // Dividend width
   parameter int DW = BASE_W                 // Divisor width
) (
   input  wire logic          clk_in,
   input  wire logic          rst_in,
   input  wire logic          start_in,      // Start pulse
   input  wire logic [NW-1:0] num_in,        // Dividend
   input  wire logic [DW-1:0] den_in,        // Divisor, never zero
   output logic               busy_out,      // Division running
   output logic               done_out,      // Result pulse
   output logic      [NW-1:0] quo_out        // Quotient
);

   localparam int SW = $clog2(NW);           // Step counter width

   // Whole state of the divider
   typedef struct packed {
      logic          busy;
      logic          done;
      logic [SW-1:0] step;
      logic [DW-1:0] rem;
      logic [NW-1:0] num;
      logic [DW-1:0] den;
      logic [NW-1:0] quo;
   } opt_div_t;

   opt_div_t      q;                         // Registered state
   opt_div_t      d;                         // Next state
   logic [DW:0]   trial;                     // Shifted remainder

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      d = q;
      d.done = 1'b0;
      trial = {q.rem, q.num[NW-1]};
      if (start_in && !q.busy) begin
         // Load operands
         d.busy = 1'b1;
         d.step = SW'(NW - 1);
         d.rem  = '0;
         d.num  = num_in;
         d.den  = den_in;
         d.quo  = '0;
      end else if (q.busy) begin
         // One restoring step
         d.num = {q.num[NW-2:0], 1'b0};
         if (trial >= {1'b0, q.den}) begin
            d.rem = DW'(trial - {1'b0, q.den});
            d.quo = {q.quo[NW-2:0], 1'b1};
         end else begin
            d.rem = trial[DW-1:0];
            d.quo = {q.quo[NW-2:0], 1'b0};
         end
         if (q.step == '0) begin
            d.busy = 1'b0;
            d.done = 1'b1;
         end else begin
            d.step = q.step - 1'b1;
         end
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign busy_out = q.busy;
   assign done_out = q.done;
   assign quo_out  = q.quo;

endmodule

// ==== opt_timer.sv ====
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module opt_timer
   import opt_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC      // Clock cycles per tick
) (
   input  wire logic              clk_in,
   input  wire logic              rst_in,
   input  wire opt_req_t          reg_req_in,      // Register request
   output logic      [DATA_W-1:0] reg_rdata_out,   // Read data
   input  wire logic              exposure_in,     // Exposure active pin
   input  wire logic              line_in_in,      // Input line pin
   output logic                   line_out_out     // Timer output line
);

   localparam int TW = $clog2(TICK_CYCLES + 1);    // Tick counter width

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [COUNT_W-1:0]  dly_cnt;          // Delay count
      logic [BASE_W-1:0]   dly_base;         // Delay tick base
      logic [COUNT_W-1:0]  dur_cnt;          // Duration count
      logic [BASE_W-1:0]   dur_base;         // Duration tick base
      opt_phase_t          phase;            // Timer phase
      logic [REMAIN_W-1:0] remain;           // Ticks left in phase
      logic [TW-1:0]       tick_cnt;         // Tick divider
      logic                tick;             // One microsecond enable
      logic [2:0]          trig_sync;        // Sync pair and history
      logic [1:0]          line_sync;        // Input line sync pair
      logic                line_out;         // Output line level
      logic                div_dur;          // Conversion target
      logic [DATA_W-1:0]   rdata;            // Read data
   } opt_state_t;

   opt_state_t         q;                    // Registered state
   opt_state_t         d;                    // Next state
   logic               trig_rise;            // Exposure start edge
   logic [NUM_W-1:0]   div_num;              // Rounded dividend
   logic [BASE_W-1:0]  div_den;              // Divisor
   logic               div_start;            // Conversion start
   logic               div_busy;             // Conversion running
   logic               div_done;             // Conversion result pulse
   logic [NUM_W-1:0]   div_quo;              // Conversion quotient
   logic [REMAIN_W-1:0] dly_prod;            // Delay in microseconds
   logic [REMAIN_W-1:0] dur_prod;            // Duration in microseconds

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Interval length in microseconds
   function automatic logic [REMAIN_W-1:0] interval(
      input logic [COUNT_W-1:0] cnt,
      input logic [BASE_W-1:0]  base
   );
      interval = REMAIN_W'(cnt) * REMAIN_W'(base);
   endfunction

   // Clamp a value into a count range
   function automatic logic [COUNT_W-1:0] clamp_count(
      input logic [NUM_W-1:0]   val,
      input logic [COUNT_W-1:0] lo
   );
      if (val > NUM_W'(COUNT_MAX)) begin
         clamp_count = COUNT_MAX;
      end else if (val < NUM_W'(lo)) begin
         clamp_count = lo;
      end else begin
         clamp_count = val[COUNT_W-1:0];
      end
   endfunction

   // Base value, zero lifted to the minimum
   function automatic logic [BASE_W-1:0] clamp_base(
      input logic [DATA_W-1:0] val
   );
      if (val > DATA_W'({BASE_W{1'b1}})) begin
         clamp_base = {BASE_W{1'b1}};
      end else if (val < DATA_W'(BASE_MIN)) begin
         clamp_base = BASE_MIN;
      end else begin
         clamp_base = val[BASE_W-1:0];
      end
   endfunction

   assign dly_prod  = interval(q.dly_cnt, q.dly_base);
   assign dur_prod  = interval(q.dur_cnt, q.dur_base);
   assign trig_rise = q.trig_sync[1] && !q.trig_sync[2];

   // ****************************************************************
   // Absolute to count conversion
   // ****************************************************************
   // Adding half a base before dividing rounds to nearest
   always_comb begin
      div_start = 1'b0;
      div_den   = q.dly_base;
      div_num   = NUM_W'(reg_req_in.wdata) + NUM_W'(q.dly_base >> 1);
      if (reg_req_in.wr && !div_busy) begin
         if (reg_req_in.addr == OFS_DLY_ABS) begin
            div_start = 1'b1;
         end else if (reg_req_in.addr == OFS_DUR_ABS) begin
            div_start = 1'b1;
            div_den   = q.dur_base;
            div_num   = NUM_W'(reg_req_in.wdata)
                        + NUM_W'(q.dur_base >> 1);
         end
      end
   end

   opt_round_div #(
      .NW (NUM_W),
      .DW (BASE_W)
   ) u_div (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .start_in (div_start),
      .num_in   (div_num),
      .den_in   (div_den),
      .busy_out (div_busy),
      .done_out (div_done),
      .quo_out  (div_quo)
   );

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      d = q;
      d.rdata = '0;

      // Pin synchronisers and edge history
      d.trig_sync = {q.trig_sync[1:0], exposure_in};
      d.line_sync = {q.line_sync[0], line_in_in};

      // Microsecond tick enable
      d.tick = 1'b0;
      if (q.tick_cnt == TW'(TICK_CYCLES - 1)) begin
         d.tick_cnt = '0;
         d.tick     = 1'b1;
      end else begin
         d.tick_cnt = q.tick_cnt + 1'b1;
      end

      // Register writes
      if (reg_req_in.wr) begin
         unique case (reg_req_in.addr)
            OFS_DLY_COUNT: d.dly_cnt  = clamp_count(
                              NUM_W'(reg_req_in.wdata),
                              DLY_COUNT_MIN);
            OFS_DLY_BASE:  d.dly_base = clamp_base(
                              reg_req_in.wdata);
            OFS_DUR_COUNT: d.dur_cnt  = clamp_count(
                              NUM_W'(reg_req_in.wdata),
                              DUR_COUNT_MIN);
            OFS_DUR_BASE:  d.dur_base = clamp_base(
                              reg_req_in.wdata);
            OFS_DLY_ABS:   d.div_dur  = div_start ? 1'b0 : q.div_dur;
            OFS_DUR_ABS:   d.div_dur  = div_start ? 1'b1 : q.div_dur;
            default: begin
               // Read-only or unmapped, ignored
            end
         endcase
      end

      // Converted count lands in its target
      if (div_done) begin
         if (q.div_dur) begin
            d.dur_cnt = clamp_count(div_quo, DUR_COUNT_MIN);
         end else begin
            d.dly_cnt = clamp_count(div_quo, DLY_COUNT_MIN);
         end
      end

      // Register reads, data valid next cycle
      if (reg_req_in.rd) begin
         unique case (reg_req_in.addr)
            OFS_DLY_COUNT: d.rdata = DATA_W'(q.dly_cnt);
            OFS_DLY_BASE:  d.rdata = DATA_W'(q.dly_base);
            OFS_DLY_ABS:   d.rdata = DATA_W'(dly_prod);
            OFS_DUR_COUNT: d.rdata = DATA_W'(q.dur_cnt);
            OFS_DUR_BASE:  d.rdata = DATA_W'(q.dur_base);
            OFS_DUR_ABS:   d.rdata = DATA_W'(dur_prod);
            OFS_OUT_LEVEL: d.rdata = DATA_W'(q.line_out);
            OFS_SNAPSHOT: begin
               d.rdata[SNAP_IN_BIT]  = q.line_sync[1];
               d.rdata[SNAP_OUT_BIT] = q.line_out;
            end
            OFS_STATUS: begin
               d.rdata[STAT_BUSY_BIT] = div_busy;
               d.rdata[STAT_RUN_BIT]  = (q.phase != OPT_IDLE);
            end
            default: begin
               // Unmapped reads return zero
            end
         endcase
      end

      // Pulse sequencer, triggers while running are ignored
      unique case (q.phase)
         OPT_IDLE: begin
            if (trig_rise) begin
               if (dly_prod == '0) begin
                  d.phase    = OPT_HIGH;
                  d.remain   = dur_prod;
                  d.line_out = 1'b1;
               end else begin
                  d.phase  = OPT_DELAY;
                  d.remain = dly_prod;
               end
            end
         end
         OPT_DELAY: begin
            if (q.tick) begin
               if (q.remain == REMAIN_W'(1)) begin
                  d.phase    = OPT_HIGH;
                  d.remain   = dur_prod;
                  d.line_out = 1'b1;
               end else begin
                  d.remain = q.remain - 1'b1;
               end
            end
         end
         OPT_HIGH: begin
            if (q.tick) begin
               if (q.remain == REMAIN_W'(1)) begin
                  d.phase    = OPT_IDLE;
                  d.line_out = 1'b0;
               end else begin
                  d.remain = q.remain - 1'b1;
               end
            end
         end
         default: begin
            d.phase    = OPT_IDLE;
            d.line_out = 1'b0;
         end
      endcase
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         q          <= '0;
         q.dly_cnt  <= DLY_COUNT_RST;
         q.dly_base <= BASE_RST;
         q.dur_cnt  <= DUR_COUNT_RST;
         q.dur_base <= BASE_RST;
         q.phase    <= OPT_IDLE;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata_out = q.rdata;
   assign line_out_out  = q.line_out;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   sequence idle_trig_s;
      q.phase == OPT_IDLE && trig_rise;
   endsequence
   sequence last_tick_s;
      q.tick && q.remain == REMAIN_W'(1);
   endsequence
   zero_delay_a: assert property (
      idle_trig_s ##0 (dly_prod == '0) |=> line_out_out)
      else $error("zero delay did not raise output");
   delay_load_a: assert property (
      idle_trig_s ##0 (dly_prod != '0) |=>
      q.phase == OPT_DELAY && q.remain == $past(dly_prod) && !line_out_out)
      else $error("delay not loaded from count and base");
   delay_range_a: assert property (
      reg_req_in.wr && reg_req_in.addr == OFS_DLY_COUNT && !div_done
      && reg_req_in.wdata <= DATA_W'(COUNT_MAX) |=>
      q.dly_cnt == $past(reg_req_in.wdata[COUNT_W-1:0]))
      else $error("delay count not stored");
   base_min_a: assert property (
      q.dly_base >= BASE_MIN && q.dur_base >= BASE_MIN)
      else $error("tick base below one");
   abs_read_a: assert property (
      reg_req_in.rd && reg_req_in.addr == OFS_DLY_ABS |=>
      reg_rdata_out == DATA_W'($past(dly_prod)))
      else $error("absolute delay read mismatch");
   dur_range_a: assert property (
      q.dur_cnt >= DUR_COUNT_MIN && q.dur_cnt <= COUNT_MAX)
      else $error("duration count out of range");
   high_start_a: assert property (
      q.phase == OPT_DELAY ##0 last_tick_s |=>
      line_out_out && q.remain == $past(dur_prod))
      else $error("pulse not started with duration");
   high_end_a: assert property (
      q.phase == OPT_HIGH ##0 last_tick_s |=>
      !line_out_out && q.phase == OPT_IDLE)
      else $error("pulse did not end");
   conv_start_a: assert property (
      reg_req_in.wr && reg_req_in.addr == OFS_DUR_ABS && !div_busy |=>
      div_busy && q.div_dur)
      else $error("absolute write did not start conversion");
   snap_bits_a: assert property (
      reg_req_in.rd && reg_req_in.addr == OFS_SNAPSHOT |=>
      reg_rdata_out == ((DATA_W'($past(q.line_out)) << SNAP_OUT_BIT)
                        | DATA_W'($past(q.line_sync[1]))))
      else $error("snapshot layout wrong");
   level_read_a: assert property (
      reg_req_in.rd && reg_req_in.addr == OFS_OUT_LEVEL |=>
      reg_rdata_out == DATA_W'($past(line_out_out)))
      else $error("output level read wrong");
   tick_gap_a: assert property (
      q.tick |=> !q.tick [*8])
      else $error("tick enable too frequent");
endmodule

// ==== opt_ext_model.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Equipment wired to the camera's exposure active pin and input line
// ****************************************************************
module opt_ext_model (
   input  wire logic clk_in,
   input  wire logic fire_in,        // Start one exposure
   input  wire logic level_in,       // Level wanted on the input line
   output logic      exposure_out,   // Exposure active pin
   output logic      lvl_out         // Input line pin
);
   logic [3:0] hold_q = 4'h0;        // Exposure length counter

   // Exposure lasts sixteen cycles, the line level follows the request
   always_ff @(posedge clk_in) begin
      if (fire_in) begin
         hold_q <= 4'hf;
      end else if (hold_q != 4'h0) begin
         hold_q <= hold_q - 4'h1;
      end
      exposure_out <= fire_in || (hold_q != 4'h0);
      lvl_out      <= level_in;
   end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   import opt_pkg::*;
   localparam int TC = 10;                    // Cycles per tick
   logic              clk_in = 1'b0;
   logic              rst_in = 1'b1;
   opt_req_t          req = '0;               // Register request
   logic [DATA_W-1:0] rdata;                  // Register read data
   logic              expo;                   // Exposure pin
   logic              lin;                    // Input line pin
   logic              line;                   // Timer output line
   logic              fire = 1'b0;            // Exposure request
   logic              lvl = 1'b0;             // Input line request
   logic              rd_p = 1'b0;            // Read in last cycle
   logic [DATA_W-1:0] expq [$];               // Expected read data
   int                n_errors = 0;
   int                comparisons = 0;
   int                cyc = 0;

   always #2.5 clk_in = ~clk_in;

   opt_timer #(.TICK_CYCLES(TC)) dut (
      .clk_in(clk_in), .rst_in(rst_in), .reg_req_in(req),
      .reg_rdata_out(rdata), .exposure_in(expo), .line_in_in(lin),
      .line_out_out(line));
   opt_ext_model ext (
      .clk_in(clk_in), .fire_in(fire), .level_in(lvl),
      .exposure_out(expo), .lvl_out(lin));

   // ****************************************************************
   // Checking and bus tasks
   // ****************************************************************
   task automatic chk(string nm, logic [DATA_W-1:0] e,
                      logic [DATA_W-1:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask

   // Measured span in cycles against its allowed window
   task automatic chk_span(string nm, int lo, int hi, int g);
      comparisons++;
      if (g < lo || g > hi) begin
         n_errors++;
         $display("MISMATCH %s exp %0d..%0d got %0d", nm, lo, hi, g);
      end
   endtask

   task automatic complete_run();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Write strobe for one cycle; the next call or idle takes over
   task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_in);
   endtask

   // Read strobe; the expected data wait in the queue
   task automatic rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
      expq.push_back(e);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk_in);
   endtask

   task automatic idle(int n);
      req <= '0;
      repeat (n) @(posedge clk_in);
   endtask

   // Read data compared in the cycle after the strobe
   always @(posedge clk_in) rd_p <= req.rd;
   always @(negedge clk_in) begin
      if (rd_p) chk("rdata", expq.pop_front(), rdata);
   end

   // Hang guard
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         complete_run();
      end
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      logic [DATA_W-1:0] k;
      int                t;
      void'($urandom(32'h2417b5e7));
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      // Reset values
      rd(OFS_DLY_COUNT, 32'h0);
      rd(OFS_DLY_BASE, 32'h1);
      rd(OFS_DUR_COUNT, 32'h1);
      rd(OFS_DUR_BASE, 32'h1);
      rd(OFS_DUR_ABS, 32'h1);
      // Count writes at the limits show in the absolute views
      wr(OFS_DLY_BASE, 32'h3);
      wr(OFS_DLY_COUNT, 32'h1388);
      rd(OFS_DLY_COUNT, 32'hfff);
      rd(OFS_DLY_ABS, 32'h2ffd);
      wr(OFS_DUR_COUNT, 32'h0);
      rd(OFS_DUR_COUNT, 32'h1);
      wr(OFS_DUR_BASE, 32'h7);
      wr(OFS_DUR_COUNT, 32'h9);
      rd(OFS_DUR_ABS, 32'h3f);
      // Absolute writes, rounded to the base of fifty
      wr(OFS_DLY_BASE, 32'h32);
      wr(OFS_DLY_ABS, 32'h7e);
      rd(OFS_STATUS, 32'h1);
      idle(40);
      rd(OFS_DLY_COUNT, 32'h3);
      rd(OFS_DLY_ABS, 32'h96);
      // Eighty over fifty rounds up to two, truncation would give one
      wr(OFS_DUR_BASE, 32'h32);
      wr(OFS_DUR_ABS, 32'h50);
      idle(40);
      rd(OFS_DUR_COUNT, 32'h2);
      k = $urandom_range(80, 2);
      wr(OFS_DUR_ABS, k * 32'h32);
      idle(40);
      rd(OFS_DUR_COUNT, k);
      rd(OFS_DUR_ABS, k * 32'h32);
      // Pulse: three ticks of delay, four ticks high
      wr(OFS_DLY_BASE, 32'h1);
      wr(OFS_DLY_COUNT, 32'h3);
      wr(OFS_DUR_BASE, 32'h2);
      wr(OFS_DUR_COUNT, 32'h2);
      rd(OFS_OUT_LEVEL, 32'h0);
      idle(1);
      lvl  <= 1'($urandom_range(1, 0));
      fire <= 1'b1;
      @(posedge clk_in);
      fire <= 1'b0;
      // Output line looked at on the falling edge, once settled
      t = 0;
      while (line !== 1'b1 && t < 200) begin
         @(negedge clk_in);
         t++;
      end
      chk_span("delay", 2 * TC + 5, 3 * TC + 4, t);
      @(posedge clk_in);
      rd(OFS_OUT_LEVEL, 32'h1);
      rd(OFS_SNAPSHOT, {15'h0, 1'b1, 15'h0, lvl});
      rd(OFS_STATUS, 32'h2);
      req <= '0;
      // Three edges of the high time already spent on the reads
      t = 3;
      while (line === 1'b1 && t < 200) begin
         @(negedge clk_in);
         t++;
      end
      chk_span("width", 4 * TC, 4 * TC, t);
      @(posedge clk_in);
      rd(OFS_OUT_LEVEL, 32'h0);
      rd(OFS_SNAPSHOT, {31'h0, lvl});
      // Read-only and unmapped places
      wr(OFS_SNAPSHOT, 32'hffffffff);
      rd(8'h40, 32'h0);
      rd(OFS_DLY_COUNT, 32'h3);
      idle(4);
      complete_run();
   end
endmodule
